// >>> dmiu_core.sv
// Data-move instruction unit: executes one move instruction per cycle
// How it works
// - Register copy reads the file register named by a 7-bit address and sends it where the destination bit says.
// - With destination bit 0 the copied value goes to the working register and the file register is untouched.
// - With destination bit 1 the value is written back to the same file register, which only tests it.
// - Register copy sets the zero flag when the moved value is zero, clears it otherwise, and touches nothing else.
// - Indirect load reads the location addressed by pointer 0 or 1 into the working register and updates zero.
// - The pointer mode field picks 00 pre-increment, 01 pre-decrement, 10 post-increment, 11 post-decrement.
// - Relative form addresses the pointer plus a signed 6-bit offset from -32 to 31 and leaves the pointer alone.
// - An incrementing access leaves the pointer one higher, a decrementing one one lower, otherwise unchanged.
// - Pre-modes update the pointer before forming the address; post-modes access the old value then update.
// - Each pointer register is 16 bits wide, covering 0000h to FFFFh.
// - Pointer steps past either end wrap modulo 65536 and raise no flag.
// - The indirect access register has no storage; naming it accesses the location its pointer addresses.
// - Load-bank puts its 5-bit literal into the bank select register and leaves every flag unchanged.
// - Load-latch puts its 7-bit literal into the program counter high latch and leaves every flag unchanged.
// - Load-literal puts its 8-bit immediate into the working register in one word and one cycle, flags unchanged.
// - Store writes the working register to the 7-bit file address in one cycle, leaving working and flags alone.
`timescale 1ns/100ps
module dmiu_core (
    input  wire logic                   i_clk,
    input  wire logic                   i_reset,
    input  wire logic                   i_valid,
    input  wire logic [13:0]            i_instr,
    input  wire logic [7:0]             i_mem_rdata,
    output dmiu_pkg::dmiu_mem_req_t     o_mem,
    output dmiu_pkg::dmiu_state_t       o_state,
    output logic                        o_retired,
    output logic                        o_unknown
);

    // Architectural state
    logic [7:0]  working_reg;
    logic        zero_reg;
    logic [4:0]  bank_reg;
    logic [6:0]  latch_reg;
    logic [15:0] ptr_reg [dmiu_pkg::NUM_PTR];
    logic [15:0] ptr_next [dmiu_pkg::NUM_PTR];
    logic        retired_reg;
    logic        unknown_reg;

    // Field extraction
    wire [3:0] op_code  = i_instr[dmiu_pkg::OP_LSB +: dmiu_pkg::OP_W];
    wire [6:0] faddr    = i_instr[dmiu_pkg::FADDR_W-1:0];
    wire       dest_f   = i_instr[dmiu_pkg::DEST_BIT];
    wire [7:0] lit8     = i_instr[dmiu_pkg::LIT_W-1:0];
    wire [4:0] lit_bank = i_instr[dmiu_pkg::BANK_W-1:0];
    wire [6:0] lit_latch = i_instr[dmiu_pkg::LATCH_W-1:0];
    wire       psel     = i_instr[dmiu_pkg::PSEL_BIT];
    wire [1:0] pointer_mode_field = i_instr[dmiu_pkg::MODE_W-1:0];
    wire [5:0] ofs      = i_instr[dmiu_pkg::OFS_W-1:0];

    // Operation decode, gated by the valid strobe
    wire register_copy_op  = i_valid && (op_code == dmiu_pkg::OP_COPY);
    wire store_working_op  = i_valid && (op_code == dmiu_pkg::OP_STORE);
    wire load_literal_op   = i_valid && (op_code == dmiu_pkg::OP_LIT);
    wire load_bank_op      = i_valid && (op_code == dmiu_pkg::OP_BANK);
    wire load_pc_latch_op  = i_valid && (op_code == dmiu_pkg::OP_LATCH);
    wire ild_step          = i_valid && (op_code == dmiu_pkg::OP_ILOAD);
    wire ild_rel           = i_valid && (op_code == dmiu_pkg::OP_ILDK);
    wire indirect_load_op  = ild_step || ild_rel;
    wire direct_op         = register_copy_op || store_working_op;
    wire known_op          = direct_op || load_literal_op || load_bank_op
                           || load_pc_latch_op || indirect_load_op;

    // File address classes; the indirect access register has no storage
    wire f_is_ind = (faddr == dmiu_pkg::FA_IND0) || (faddr == dmiu_pkg::FA_IND1);
    wire f_ind_n  = faddr[0];
    wire f_is_ptr = (faddr[6:2] == dmiu_pkg::FA_PTR_PAGE);
    wire f_ptr_n  = faddr[1];
    wire f_ptr_hi = faddr[0];

    // Selected pointer and its neighbours; plain 16-bit math wraps for free
    wire [15:0] ptr_sel  = ptr_reg[psel];
    wire [15:0] ptr_inc  = ptr_sel + 16'h0001;
    wire [15:0] ptr_dec  = ptr_sel - 16'h0001;
    wire        mode_dec = pointer_mode_field[dmiu_pkg::MODE_DEC_BIT];
    wire        mode_post = pointer_mode_field[dmiu_pkg::MODE_POST_BIT];
    wire [15:0] ptr_step = mode_dec ? ptr_dec : ptr_inc;
    wire [15:0] ofs_ext  = {{(dmiu_pkg::PTR_W-dmiu_pkg::OFS_W){ofs[dmiu_pkg::OFS_W-1]}}, ofs};
    wire [15:0] ptr_rel  = ptr_sel + ofs_ext;

    // Effective indirect address: pre-modes see the stepped value
    wire [15:0] ild_addr = ild_rel   ? ptr_rel :
                           mode_post ? ptr_sel : ptr_step;

    // Direct address, redirected through a pointer for the indirect slot
    wire [15:0] dir_addr = f_is_ind ? ptr_reg[f_ind_n] : {9'h000, faddr};

    // Pointer bytes are served here, not by memory
    wire [15:0] ptr_f    = ptr_reg[f_ptr_n];
    wire [7:0]  ptr_byte = f_ptr_hi ? ptr_f[15:8] : ptr_f[7:0];
    wire        int_hit  = direct_op && f_is_ptr;

    // Value moved by the copy and indirect load
    wire [7:0] rd_data   = int_hit ? ptr_byte : i_mem_rdata;
    wire       rd_zero   = (rd_data == 8'h00);
    wire       copy_back = register_copy_op && dest_f;
    wire       copy_w    = register_copy_op && !dest_f;

    // Memory request; combinational so each move finishes in its cycle
    wire        mem_re    = (register_copy_op || indirect_load_op) && !int_hit;
    wire        mem_we    = (store_working_op || copy_back) && !int_hit;
    wire [7:0]  wr_data   = store_working_op ? working_reg : rd_data;
    wire [15:0] mem_addr  = indirect_load_op ? ild_addr : dir_addr;

    assign o_mem.addr  = mem_addr;
    assign o_mem.wdata = wr_data;
    assign o_mem.we    = mem_we;
    assign o_mem.re    = mem_re;

    // Next working register and zero flag
    wire [7:0] working_next = (copy_w || indirect_load_op) ? rd_data :
                              load_literal_op ? lit8 :
                              working_reg;
    wire       zero_next    = (register_copy_op || indirect_load_op) ? rd_zero : zero_reg;
    wire [4:0] bank_next    = load_bank_op ? lit_bank : bank_reg;
    wire [6:0] latch_next   = load_pc_latch_op ? lit_latch : latch_reg;

    // Internal pointer-byte writes from store or copy-back
    wire       ptr_wr    = int_hit && (store_working_op || dest_f);

    // One pointer per entry: step, byte write, or hold
    genvar gi;
    generate
        for (gi = 0; gi < dmiu_pkg::NUM_PTR; gi++) begin : g_ptr
            wire step_here = ild_step && (psel == 1'(gi));
            wire wr_here   = ptr_wr && (f_ptr_n == 1'(gi));
            wire [15:0] wr_val = f_ptr_hi ? {wr_data, ptr_reg[gi][7:0]}
                                          : {ptr_reg[gi][15:8], wr_data};
            // Relative form never moves the pointer
            assign ptr_next[gi] = step_here ? ptr_step :
                                  wr_here   ? wr_val   :
                                  ptr_reg[gi];
            always_ff @(posedge i_clk) begin
                if (i_reset) begin
                    ptr_reg[gi] <= dmiu_pkg::RST_PTR;
                end else begin
                    ptr_reg[gi] <= ptr_next[gi];
                end
            end
        end
    endgenerate

    // Architectural registers; all effects of one word land on one edge
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            working_reg <= dmiu_pkg::RST_WORKING;
            zero_reg    <= dmiu_pkg::RST_ZERO;
            bank_reg    <= dmiu_pkg::RST_BANK;
            latch_reg   <= dmiu_pkg::RST_LATCH;
        end else begin
            working_reg <= working_next;
            zero_reg    <= zero_next;
            bank_reg    <= bank_next;
            latch_reg   <= latch_next;
        end
    end

    // Completion pulses, one cycle after the word
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            retired_reg <= 1'b0;
            unknown_reg <= 1'b0;
        end else begin
            retired_reg <= known_op;
            unknown_reg <= i_valid && !known_op;
        end
    end

    assign o_retired        = retired_reg;
    assign o_unknown        = unknown_reg;
    assign o_state.working  = working_reg;
    assign o_state.zero     = zero_reg;
    assign o_state.bank     = bank_reg;
    assign o_state.pc_latch = latch_reg;
    assign o_state.ptr0     = ptr_reg[0];
    assign o_state.ptr1     = ptr_reg[1];

    // Checks on the executed behaviour
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    wire copy_plain = register_copy_op && !f_is_ind && !f_is_ptr;

    // Copy address comes straight from the 7-bit field
    property p_copy_addr;
        copy_plain |-> mem_re && (mem_addr == {9'h000, faddr});
    endproperty
    a_copy_addr: assert property (p_copy_addr) else $error("copy address wrong");

    // Copy to working register, with zero and retire together
    property p_copy_w;
        copy_w |=> (working_reg == $past(rd_data)) && (zero_reg == $past(rd_zero)) && o_retired;
    endproperty
    a_copy_w: assert property (p_copy_w) else $error("copy to working wrong");

    // Copy back writes the same value and keeps working register
    property p_copy_back;
        (copy_back && !f_is_ptr) |-> mem_we && (wr_data == i_mem_rdata) ##1 $stable(working_reg);
    endproperty
    a_copy_back: assert property (p_copy_back) else $error("copy back wrong");

    // Zero flag follows the moved value, bank and latch untouched
    property p_copy_zero;
        register_copy_op |=> (zero_reg == ($past(rd_data) == 8'h00)) && $stable(bank_reg) && $stable(latch_reg);
    endproperty
    a_copy_zero: assert property (p_copy_zero) else $error("copy zero flag wrong");

    // Indirect load fills working register and zero
    property p_iload;
        indirect_load_op |=> (working_reg == $past(i_mem_rdata)) && (zero_reg == ($past(i_mem_rdata) == 8'h00));
    endproperty
    a_iload: assert property (p_iload) else $error("indirect load wrong");

    // Pre-increment addresses the stepped pointer and keeps it
    property p_pre_inc;
        (ild_step && (pointer_mode_field == dmiu_pkg::MODE_PRE_INC))
            |-> (mem_addr == ptr_inc) ##1 (ptr_reg[$past(psel)] == $past(ptr_inc));
    endproperty
    a_pre_inc: assert property (p_pre_inc) else $error("pre-increment wrong");

    // Post-decrement addresses the old pointer then steps down
    property p_post_dec;
        (ild_step && (pointer_mode_field == dmiu_pkg::MODE_POST_DEC))
            |-> (mem_addr == ptr_sel) ##1 (ptr_reg[$past(psel)] == $past(ptr_dec));
    endproperty
    a_post_dec: assert property (p_post_dec) else $error("post-decrement wrong");

    // Pre-decrement and post-increment
    property p_other_modes;
        ild_step && (pointer_mode_field == dmiu_pkg::MODE_PRE_DEC) |-> mem_addr == ptr_dec;
    endproperty
    a_other_modes: assert property (p_other_modes) else $error("pre-decrement wrong");

    property p_post_inc;
        ild_step && (pointer_mode_field == dmiu_pkg::MODE_POST_INC) |-> mem_addr == ptr_sel;
    endproperty
    a_post_inc: assert property (p_post_inc) else $error("post-increment wrong");

    // Relative form uses signed offset and never moves the pointer
    property p_rel;
        ild_rel |-> (mem_addr == ptr_sel + ofs_ext) ##1 (ptr_reg[$past(psel)] == $past(ptr_sel));
    endproperty
    a_rel: assert property (p_rel) else $error("relative offset wrong");

    // Wrap from the top of the range lands on zero
    property p_wrap;
        (ild_step && !mode_dec && (ptr_sel == 16'hFFFF)) |=> ptr_reg[$past(psel)] == 16'h0000;
    endproperty
    a_wrap: assert property (p_wrap) else $error("pointer wrap wrong");

    // Indirect slot redirects through its pointer
    property p_ind_slot;
        (register_copy_op && f_is_ind) |-> mem_re && (mem_addr == ptr_reg[f_ind_n]);
    endproperty
    a_ind_slot: assert property (p_ind_slot) else $error("indirect slot wrong");

    // Literal loads and flags
    property p_bank;
        load_bank_op |=> (bank_reg == $past(lit_bank)) && $stable(zero_reg) && $stable(working_reg);
    endproperty
    a_bank: assert property (p_bank) else $error("bank load wrong");

    property p_latch;
        load_pc_latch_op |=> (latch_reg == $past(lit_latch)) && $stable(zero_reg) && $stable(bank_reg);
    endproperty
    a_latch: assert property (p_latch) else $error("latch load wrong");

    property p_lit;
        load_literal_op |=> (working_reg == $past(lit8)) && $stable(zero_reg) && o_retired;
    endproperty
    a_lit: assert property (p_lit) else $error("literal load wrong");

    // Store drives working register out and changes nothing here
    property p_store;
        (store_working_op && !f_is_ptr) |-> mem_we && (wr_data == working_reg) && !mem_re
            ##1 $stable(working_reg) && $stable(zero_reg);
    endproperty
    a_store: assert property (p_store) else $error("store wrong");

    // Pointer width covers the full 16-bit range
    property p_ptr_width;
        (ild_step && mode_dec && (ptr_sel == 16'h0000)) |=> ptr_reg[$past(psel)] == 16'hFFFF;
    endproperty
    a_ptr_width: assert property (p_ptr_width) else $error("pointer range wrong");

    // Main scenarios
    c_copy_zero: cover property (copy_w && rd_zero ##1 zero_reg);
    c_wrap_down: cover property (ild_step && mode_dec && ptr_sel == 16'h0000);
    c_rel_neg:   cover property (ild_rel && ofs[dmiu_pkg::OFS_W-1]);
    c_store_ptr: cover property (store_working_op && f_is_ptr);

endmodule

// >>> dmiu_pkg.sv
// Constants, field layout and carrier types of the data-move instruction unit
package dmiu_pkg;

    // Instruction word layout
    localparam int INSTR_W   = 14;
    localparam int OP_LSB    = 10;
    localparam int OP_W      = 4;
    localparam int DEST_BIT  = 7;
    localparam int FADDR_W   = 7;
    localparam int LIT_W     = 8;
    localparam int BANK_W    = 5;
    localparam int LATCH_W   = 7;
    localparam int PSEL_BIT  = 6;
    localparam int MODE_W    = 2;
    localparam int OFS_W     = 6;
    localparam int PTR_W     = 16;
    localparam int DATA_W    = 8;
    localparam int NUM_PTR   = 2;

    // Operation codes in the top field
    localparam logic [3:0] OP_COPY  = 4'h1;
    localparam logic [3:0] OP_STORE = 4'h2;
    localparam logic [3:0] OP_LIT   = 4'h3;
    localparam logic [3:0] OP_BANK  = 4'h4;
    localparam logic [3:0] OP_LATCH = 4'h5;
    localparam logic [3:0] OP_ILOAD = 4'h6;
    localparam logic [3:0] OP_ILDK  = 4'h7;

    // Pointer mode field codes
    localparam logic [1:0] MODE_PRE_INC  = 2'h0;
    localparam logic [1:0] MODE_PRE_DEC  = 2'h1;
    localparam logic [1:0] MODE_POST_INC = 2'h2;
    localparam logic [1:0] MODE_POST_DEC = 2'h3;
    localparam int MODE_POST_BIT = 1;
    localparam int MODE_DEC_BIT  = 0;

    // File addresses redirected through a pointer or served inside the unit
    localparam logic [6:0] FA_IND0     = 7'h00;
    localparam logic [6:0] FA_IND1     = 7'h01;
    localparam logic [4:0] FA_PTR_PAGE = 5'h01;

    // Reset values
    localparam logic [7:0]  RST_WORKING = 8'h00;
    localparam logic [4:0]  RST_BANK    = 5'h00;
    localparam logic [6:0]  RST_LATCH   = 7'h00;
    localparam logic [15:0] RST_PTR     = 16'h0000;
    localparam logic        RST_ZERO    = 1'b0;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        we;
        logic        re;
    } dmiu_mem_req_t;

    typedef struct packed {
        logic [15:0] ptr1;
        logic [15:0] ptr0;
        logic [6:0]  pc_latch;
        logic [4:0]  bank;
        logic        zero;
        logic [7:0]  working;
    } dmiu_state_t;

endpackage

// >>> dmiu_mem_model.sv
// Behavioural data memory that serves the move unit's single-cycle accesses
`timescale 1ns/100ps
module dmiu_mem_model (
    input  wire logic                    i_clk,
    input  wire dmiu_pkg::dmiu_mem_req_t i_mem,
    output logic [7:0]                   o_rdata
);
    logic [7:0] store_reg [logic [15:0]];
    logic [7:0] idle_reg = 8'h5A;
    int         wr_count = 0;

    // Unwritten cells read an address pattern, so a wrong address shows up
    function automatic logic [7:0] peek(input logic [15:0] a);
        return store_reg.exists(a) ? store_reg[a] : (a[7:0] ^ a[15:8] ^ 8'hC3);
    endfunction

    // Backdoor preload for the bench
    function automatic void poke(input logic [15:0] a, input logic [7:0] d);
        store_reg[a] = d;
        wr_count++;
    endfunction

    // Writes land at the edge that ends the access cycle
    always @(posedge i_clk) begin
        idle_reg <= ~idle_reg;
        if (i_mem.we) begin
            poke(i_mem.addr, i_mem.wdata);
        end
    end

    // No read strobe: toggling junk, never the last value read
    always @(i_mem or idle_reg or wr_count) begin
        o_rdata = i_mem.re ? peek(i_mem.addr) : idle_reg;
    end
endmodule

// >>> test_data_move_instruction_unit.sv
// Self-checking testbench for the data-move instruction unit
`timescale 1ns/100ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin failures++; \
    $display("mismatch at %0t: got %h expected %h", $time, (got), (exp)); end end
module test_data_move_instruction_unit;
    logic                    i_clk = 1'b0;
    logic                    i_reset = 1'b1;
    logic                    i_valid = 1'b0;
    logic [13:0]             i_instr = 14'h0000;
    logic [7:0]              mem_rdata;
    dmiu_pkg::dmiu_mem_req_t mem_req;
    dmiu_pkg::dmiu_state_t   st;
    dmiu_pkg::dmiu_state_t   saved;
    logic                    retired;
    logic                    unknown;
    int                      failures = 0;
    int                      n_compared = 0;
    // Pointer walk: mode, value read, pointer after; starts at FFFF
    logic [1:0]              md [9] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h3, 2'h0, 2'h0, 2'h3, 2'h2};
    logic [7:0]              dv [9] = '{8'h11, 8'h22, 8'h00, 8'h00, 8'h22, 8'h22, 8'h11, 8'h11, 8'h22};
    logic [15:0]             pv [9] = '{16'h0000, 16'hFFFF, 16'hFFFE, 16'hFFFF, 16'hFFFE,
                                        16'hFFFF, 16'h0000, 16'hFFFF, 16'h0000};

    // 25 MHz core clock
    always #20 i_clk = ~i_clk;

    dmiu_core u_dut (
        .i_clk       (i_clk),
        .i_reset     (i_reset),
        .i_valid     (i_valid),
        .i_instr     (i_instr),
        .i_mem_rdata (mem_rdata),
        .o_mem       (mem_req),
        .o_state     (st),
        .o_retired   (retired),
        .o_unknown   (unknown)
    );

    dmiu_mem_model u_mem (
        .i_clk   (i_clk),
        .i_mem   (mem_req),
        .o_rdata (mem_rdata)
    );

    // Instruction word builders
    function automatic logic [13:0] w_copy(input logic d, input logic [6:0] f);
        return {dmiu_pkg::OP_COPY, 2'h0, d, f};
    endfunction
    function automatic logic [13:0] w_store(input logic [6:0] f);
        return {dmiu_pkg::OP_STORE, 3'h0, f};
    endfunction
    function automatic logic [13:0] w_lit(input logic [7:0] k);
        return {dmiu_pkg::OP_LIT, 2'h0, k};
    endfunction
    function automatic logic [13:0] w_bank(input logic [4:0] k);
        return {dmiu_pkg::OP_BANK, 5'h00, k};
    endfunction
    function automatic logic [13:0] w_latch(input logic [6:0] k);
        return {dmiu_pkg::OP_LATCH, 3'h0, k};
    endfunction
    function automatic logic [13:0] w_step(input logic n, input logic [1:0] m);
        return {dmiu_pkg::OP_ILOAD, 3'h0, n, 4'h0, m};
    endfunction
    function automatic logic [13:0] w_rel(input logic n, input logic [5:0] k);
        return {dmiu_pkg::OP_ILDK, 3'h0, n, k};
    endfunction

    // Present a word; consecutive calls run back to back
    task automatic issue(input logic [13:0] w);
        @(posedge i_clk);
        i_valid <= 1'b1;
        i_instr <= w;
    endtask

    // Let the last word execute, then sample settled outputs
    task automatic done();
        @(posedge i_clk);
        i_valid <= 1'b0;
        #1;
    endtask

    task automatic run(input logic [13:0] w);
        issue(w);
        done();
    endtask

    task automatic wrap_up();
        $display("compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Hang guard, 10,000 cycles, far beyond the fewer than a hundred the run needs
    initial begin
        #400000;
        failures++;
        wrap_up();
    end

    initial begin
        repeat (12) @(posedge i_clk);
        i_reset <= 1'b0;
        @(posedge i_clk);
        #1;
        `CHK(st, '0)
        `CHK({retired, unknown, mem_req.we, mem_req.re}, 4'h0)
        $display("test reset done");

        // Copy: to working, back to file, zero from moved value
        u_mem.poke(16'h007F, 8'h00);
        u_mem.poke(16'h0020, 8'h3C);
        issue(w_copy(1'b0, 7'h7F));
        issue(w_copy(1'b0, 7'h20));
        issue(w_copy(1'b1, 7'h7F));
        done();
        `CHK(st.working, 8'h3C)
        `CHK(st.zero, 1'b1)
        `CHK(retired, 1'b1)
        `CHK(u_mem.peek(16'h007F), 8'h00)
        run(w_copy(1'b1, 7'h20));
        `CHK(st.zero, 1'b0)
        `CHK(st.working, 8'h3C)
        `CHK(u_mem.peek(16'h0020), 8'h3C)
        $display("test copy done");

        // Literal loads must not touch the zero flag, even a zero literal
        run(w_copy(1'b1, 7'h7F));
        issue(w_lit(8'h00));
        issue(w_bank(5'h1F));
        issue(w_latch(7'h7F));
        done();
        `CHK(st.working, 8'h00)
        `CHK(st.zero, 1'b1)
        `CHK(st.bank, 5'h1F)
        `CHK(st.pc_latch, 7'h7F)
        issue(w_lit(8'hA5));
        issue(w_bank(5'h00));
        issue(w_latch(7'h00));
        done();
        `CHK(st.working, 8'hA5)
        `CHK(st.bank, 5'h00)
        `CHK(st.pc_latch, 7'h00)
        `CHK(st.zero, 1'b1)
        $display("test literal done");

        // Store leaves working and zero alone
        run(w_store(7'h55));
        `CHK(u_mem.peek(16'h0055), 8'hA5)
        `CHK(st.working, 8'hA5)
        `CHK(st.zero, 1'b1)
        `CHK(retired, 1'b1)
        $display("test store done");

        // Pointer modes through both wrap points
        run(w_lit(8'hFF));
        run(w_store(7'h04));
        run(w_store(7'h05));
        `CHK(st.ptr0, 16'hFFFF)
        u_mem.poke(16'h0000, 8'h11);
        u_mem.poke(16'hFFFF, 8'h22);
        u_mem.poke(16'hFFFE, 8'h00);
        for (int i = 0; i < 9; i++) begin
            run(w_step(1'b0, md[i]));
            `CHK(st.working, dv[i])
            `CHK(st.ptr0, pv[i])
            `CHK(st.zero, dv[i] == 8'h00)
        end
        `CHK(st.ptr1, 16'h0000)
        run(w_step(1'b1, dmiu_pkg::MODE_POST_DEC));
        `CHK(st.working, 8'h11)
        `CHK(st.ptr1, 16'hFFFF)
        `CHK(st.ptr0, 16'h0000)
        $display("test pointer modes done");

        // Relative offsets at both ends of the range, pointer kept
        u_mem.poke(16'hFFDF, 8'h77);
        u_mem.poke(16'h001E, 8'h00);
        run(w_rel(1'b1, 6'h20));
        `CHK(st.working, 8'h77)
        `CHK(st.ptr1, 16'hFFFF)
        run(w_rel(1'b1, 6'h1F));
        `CHK(st.working, 8'h00)
        `CHK(st.zero, 1'b1)
        `CHK(st.ptr1, 16'hFFFF)
        $display("test relative done");

        // Indirect slots reach memory through the pointers
        run(w_copy(1'b0, 7'h01));
        `CHK(st.working, 8'h22)
        `CHK(st.ptr1, 16'hFFFF)
        run(w_store(7'h00));
        `CHK(u_mem.peek(16'h0000), 8'h22)
        $display("test indirect slot done");

        // Pointer bytes are served inside the unit, never by memory
        run(w_store(7'h06));
        `CHK(st.ptr1, 16'hFF22)
        `CHK(u_mem.peek(16'h0006), 8'hC5)
        issue(w_copy(1'b0, 7'h07));
        #1;
        `CHK({mem_req.we, mem_req.re}, 2'h0)
        done();
        `CHK(st.working, 8'hFF)
        `CHK(st.zero, 1'b0)
        $display("test pointer bytes done");

        // Unused op code changes no state
        saved = st;
        run(14'h0000);
        `CHK(unknown, 1'b1)
        `CHK(retired, 1'b0)
        `CHK(st, saved)
        $display("test unused op done");
        wrap_up();
    end
endmodule
